//--- int_arb_pkg.sv
/*
  Shared constants for the interrupt arbitration and low-power sequencer.
  Assumes a single bus clock domain and one-hot style request vectors.
*/
package int_arb_pkg;
  // Number of hardware request sources (priority 1 upward)
  localparam int          NUM_SRC      = 11;
  // Width of the winning-source code
  localparam int          CODE_W       = 4;
  // Code for the software interrupt, priority level zero
  localparam logic [3:0]  CODE_SWI     = 4'h0;
  // Code shown when nothing is latched
  localparam logic [3:0]  CODE_NONE    = 4'hF;
  // Width of the program counter
  localparam int          PC_W         = 16;
  // Return address offset for hardware requests
  localparam logic [15:0] HW_PC_ADJ    = 16'h0001;
  // Number of stacked bytes (CCR, A, X, PCH, PCL)
  localparam logic [2:0]  STACK_BYTES  = 3'h5;
endpackage : int_arb_pkg

//--- int_arb.sv
/*
  Interrupt arbitration and exception sequencing with low-power control.
  Assumes the core signals instruction boundaries, low-power opcodes,
  software interrupt and return from interrupt as one-cycle pulses on mclk,
  and that peripheral requests are already synchronous to mclk.
*/
`timescale 1ns/1ns
`default_nettype none

module int_arb
  import int_arb_pkg::*;
#(
  parameter int NSRC = int_arb_pkg::NUM_SRC
)
(
  // Clock, reset, enable
  input  wire  logic                          mclk,
  input  wire  logic                          rst,
  input  wire  logic                          ce,
  // Peripheral requests and their enables
  input  wire  logic [NSRC-1:0]               irq_req,
  input  wire  logic [NSRC-1:0]               irq_en,
  // Core events
  input  wire  logic                          insn_done,
  input  wire  logic                          swi_exec,
  input  wire  logic                          rti_exec,
  input  wire  logic                          wait_exec,
  input  wire  logic                          stop_exec,
  input  wire  logic [int_arb_pkg::PC_W-1:0]  program_counter,
  // Exception controls to the core
  output logic                                take_exc,
  output logic [int_arb_pkg::CODE_W-1:0]      vector_code,
  output logic [int_arb_pkg::PC_W-1:0]        stack_pc,
  output logic                                stack_regs,
  output logic                                stack_hreg,
  output logic                                imask,
  output logic                                restore_regs,
  output logic                                prefetch_op,
  output logic                                core_clk_en,
  output logic                                stop_mode
);
  import int_arb_pkg::*;

  // Codes 1..NSRC must stay clear of the idle code; refused at elaboration
  if (NSRC < 1 || NSRC > 14)
  begin : g_nsrc_bad
    $error("NSRC must be 1..14 to fit the code width");
  end

  typedef enum logic [1:0]
  {
    ST_RUN   = 2'b00,
    ST_WAIT  = 2'b01,
    ST_STOP  = 2'b10
  } pwr_e;

  // Lowest-index pending source; index 0 is level 1
  function automatic logic [3:0] pick(input logic [NSRC-1:0] v);
    logic [3:0] r;
    r = CODE_NONE;
    for (int i = NSRC - 1; i >= 0; i--)
      if (v[i])
        r = 4'(i + 1);
    return r;
  endfunction

  pwr_e                 pwr_reg, pwr_next;       // Low-power state
  logic                 imask_reg, imask_next;   // Global mask
  logic                 take_reg, take_next;     // Exception pulse
  logic [3:0]           code_reg, code_next;     // Latched winner
  logic [PC_W-1:0]      spc_reg, spc_next;       // Stacked address
  logic                 rest_reg, rest_next;     // Restore pulse
  logic                 pref_reg, pref_next;     // Prefetch pulse
  logic [NSRC-1:0]      active;                  // Enabled and pending
  logic [3:0]           winner;                  // Arbitration result
  logic                 wake;                    // Low-power exit cause

  assign active = irq_req & irq_en;
  assign winner = pick(active);
  // Any enabled request wakes; mask was cleared on entry anyway
  assign wake   = |active;

  // Next-state computation for sequencing
  always_comb
  begin
    pwr_next   = pwr_reg;
    imask_next = imask_reg;
    take_next  = 1'b0;
    code_next  = code_reg;
    spc_next   = spc_reg;
    rest_next  = 1'b0;
    pref_next  = 1'b0;
    case (pwr_reg)
      ST_RUN:
      begin
        if (swi_exec)
        begin
          take_next  = 1'b1;
          code_next  = CODE_SWI;
          spc_next   = program_counter;
          imask_next = 1'b1;
        end
        else if (rti_exec)
        begin
          rest_next  = 1'b1;
          pref_next  = 1'b1;
          imask_next = 1'b0;
          if (wake)
          begin
            take_next  = 1'b1;
            code_next  = winner;
            spc_next   = program_counter - HW_PC_ADJ;
            imask_next = 1'b1;
          end
        end
        else if (wait_exec || stop_exec)
        begin
          imask_next = 1'b0;
          pwr_next   = stop_exec ? ST_STOP : ST_WAIT;
        end
        else if (insn_done && !imask_reg && wake)
        begin
          take_next  = 1'b1;
          code_next  = winner;
          spc_next   = program_counter - HW_PC_ADJ;
          imask_next = 1'b1;
        end
      end
      ST_WAIT, ST_STOP:
      begin
        if (wake)
        begin
          pwr_next   = ST_RUN;
          take_next  = 1'b1;
          code_next  = winner;
          spc_next   = program_counter - HW_PC_ADJ;
          imask_next = 1'b1;
        end
      end
      default:
        pwr_next = ST_RUN;
    endcase
  end

  // Registers; reset acts at once, outside arbitration
  // reset overrides all
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      pwr_reg   <= ST_RUN;
      imask_reg <= 1'b1;
      take_reg  <= 1'b0;
      code_reg  <= CODE_NONE;
      spc_reg   <= '0;
      rest_reg  <= 1'b0;
      pref_reg  <= 1'b0;
    end
    else if (ce)
    begin
      pwr_reg   <= pwr_next;
      imask_reg <= imask_next;
      take_reg  <= take_next;
      code_reg  <= code_next;
      spc_reg   <= spc_next;
      rest_reg  <= rest_next;
      pref_reg  <= pref_next;
    end
  end

  assign vector_code  = code_reg;
  assign take_exc     = take_reg;
  assign stack_pc     = spc_reg;
  assign stack_regs   = take_reg;
  assign stack_hreg   = 1'b0;
  assign imask        = imask_reg;
  assign restore_regs = rest_reg;
  assign prefetch_op  = pref_reg;
  assign core_clk_en  = (pwr_reg == ST_RUN);
  assign stop_mode    = (pwr_reg == ST_STOP);

  AST_MASK_BLOCK: assert property (@(posedge mclk) disable iff (rst)
    (ce && pwr_reg == ST_RUN && imask_reg && insn_done && !swi_exec
     && !rti_exec) |=> !take_reg)
    else $error("hardware request taken while masked");
  AST_SWI_TAKE: assert property (@(posedge mclk) disable iff (rst)
    (ce && pwr_reg == ST_RUN && swi_exec) |=> take_reg && code_reg == CODE_SWI)
    else $error("software interrupt not taken");
  AST_SWI_PC: assert property (@(posedge mclk) disable iff (rst)
    (ce && pwr_reg == ST_RUN && swi_exec)
    |=> stack_pc == $past(program_counter))
    else $error("software return address wrong");
  AST_HW_PC: assert property (@(posedge mclk) disable iff (rst)
    (take_reg && code_reg != CODE_SWI && $past(ce) && $past(pwr_reg) == ST_RUN
     && !$past(rti_exec))
    |-> stack_pc == $past(program_counter) - HW_PC_ADJ)
    else $error("hardware return address wrong");
  AST_ENTRY_MASK: assert property (@(posedge mclk) disable iff (rst)
    take_reg |-> imask_reg)
    else $error("mask not set on entry");
  AST_LP_MASK: assert property (@(posedge mclk) disable iff (rst)
    (ce && pwr_reg == ST_RUN && !swi_exec && !rti_exec && wait_exec)
    |=> !imask_reg && !core_clk_en)
    else $error("wait did not clear mask or halt");
  AST_LP_STAY: assert property (@(posedge mclk) disable iff (rst)
    (ce && pwr_reg != ST_RUN && !wake) |=> pwr_reg == $past(pwr_reg))
    else $error("low power left without interrupt");
  AST_RTI_PREF: assert property (@(posedge mclk) disable iff (rst)
    (ce && pwr_reg == ST_RUN && !swi_exec && rti_exec)
    |=> prefetch_op && restore_regs)
    else $error("return did not prefetch");
  AST_PRIO: assert property (@(posedge mclk) disable iff (rst)
    (ce && pwr_reg == ST_RUN && !imask_reg && insn_done && !swi_exec
     && !rti_exec && !wait_exec && !stop_exec && wake)
    |=> code_reg == $past(winner))
    else $error("winner not latched");
  AST_NO_H: assert property (@(posedge mclk) disable iff (rst)
    !stack_hreg)
    else $error("high index stacked");

endmodule // int_arb

`default_nettype wire

//--- periph_model.sv
/*
  Partner model of the requesting peripherals: level flags that the bench
  raises and that drop once the block has taken their exception.
  Assumes the single mclk domain of the arbiter.
*/
`timescale 1ns/1ns
`default_nettype none
module periph_model
#(
  parameter int NSRC = 11
)
(
  // Clock and reset
  input  wire logic                             mclk,
  input  wire logic                             rst,
  // Flag raise from the bench, acknowledge from the block
  input  wire logic [NSRC-1:0]                  raise,
  input  wire logic                             take_exc,
  input  wire logic [int_arb_pkg::CODE_W-1:0]   vector_code,
  // Level requests towards the block
  output var  logic [NSRC-1:0]                  irq_req
);
  import int_arb_pkg::*;
  // Flags hold until served, so a late acknowledge leaves them pending
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      irq_req <= '0;
    // A raise in the acknowledge cycle survives: the set wins
    else if (take_exc && vector_code != CODE_SWI && vector_code <= NSRC)
      irq_req <= (irq_req & ~(NSRC'(1) << (vector_code - 1))) | raise;
    else
      irq_req <= irq_req | raise;
  end
endmodule // periph_model
`default_nettype wire

//--- int_arb_tb.sv
/*
  Self-checking bench: random core events and requests, a behavioural
  model compared every cycle. Assumes the arbiter and periph_model.
*/
`timescale 1ns/1ns
`default_nettype none
module int_arb_tb;
  import int_arb_pkg::*;
  logic mclk, rst, ce, ins, software_interrupt_instruction, return_from_interrupt, wt, sp, m_take, m_pf, m_mask;
  logic [10:0] en, raise, req, req_s;
  logic [15:0] pc, m_pc, spc;
  logic [3:0]  code, m_code;
  logic take, regs, hreg, imask, rest, pf, clk_en, stop_m;
  int   mismatches, tests_run, cycles, m_lp, w;
  logic [31:0] seed, r;
  int_arb #(.NSRC(11)) i_dut (.mclk(mclk), .rst(rst), .ce(ce),
    .irq_req(req), .irq_en(en), .insn_done(ins), .swi_exec(software_interrupt_instruction),
    .rti_exec(return_from_interrupt), .wait_exec(wt), .stop_exec(sp), .program_counter(pc),
    .take_exc(take), .vector_code(code), .stack_pc(spc), .stack_regs(regs),
    .stack_hreg(hreg), .imask(imask), .restore_regs(rest),
    .prefetch_op(pf), .core_clk_en(clk_en), .stop_mode(stop_m));
  periph_model #(.NSRC(11)) i_per (.mclk(mclk), .rst(rst), .raise(raise),
    .take_exc(take), .vector_code(code), .irq_req(req));
  // Free-running bus clock
  initial
  begin
    mclk = 0;
    forever #20 mclk = ~mclk;
  end
  task summarize;
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Hang guard, well above the planned run
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 5000) begin mismatches++; summarize; end
  end
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, g); end
  endtask
  function automatic int win(input logic [10:0] v);
    for (int i = 0; i < 11; i++) if (v[i]) return i + 1;
    return 0;
  endfunction
  task mreset;
    m_mask = 1; m_code = CODE_NONE; m_pc = 0; m_lp = 0; m_take = 0; m_pf = 0;
    {ins, software_interrupt_instruction, return_from_interrupt, wt, sp, raise} = '0;
    ce = 1;
  endtask
  task take_it(input logic [3:0] c, input logic [15:0] p);
    m_take = 1; m_code = c; m_pc = p; m_mask = 1;
  endtask
  // Outputs while reset is held, whatever mode was running
  task rchk;
    chk("rst_take", 0, take);
    chk("rst_mask", 1, imask);
    chk("rst_code", CODE_NONE, code);
    chk("rst_clk", 1, clk_en);
    chk("rst_stop", 0, stop_m);
    chk("rst_pc", 0, spc);
    chk("rst_rest", 0, rest);
    chk("rst_pref", 0, pf);
  endtask
  initial
  begin
    seed = 32'h7809_04a9; rst = 1; en = '1; pc = 0; mreset;
    repeat (10) @(posedge mclk);
    #1 rchk; rst = 0; req_s = req;
    for (int c = 0; c < 3000; c++) begin
      @(posedge mclk); #1;
      // Model takes the inputs the block sampled; a low enable freezes all
      if (ce) begin
        w = win(req_s & en); m_take = 0; m_pf = 0;
        if (m_lp != 0) begin
          if (w != 0) begin take_it(4'(w), pc - HW_PC_ADJ); m_lp = 0; end
        end
        else if (software_interrupt_instruction) take_it(CODE_SWI, pc);
        else if (return_from_interrupt) begin m_pf = 1;
          if (w != 0) take_it(4'(w), pc - HW_PC_ADJ); else m_mask = 0; end
        else if (wt || sp) begin m_lp = sp ? 2 : 1; m_mask = 0; end
        else if (ins && !m_mask && w != 0) take_it(4'(w), pc - HW_PC_ADJ);
      end
      chk("take_exc", m_take, take);
      chk("vector_code", m_code, code);
      chk("stack_pc", m_pc, spc);
      chk("imask", m_mask, imask);
      chk("prefetch_op", m_pf, pf);
      chk("restore_regs", m_pf, rest);
      chk("core_clk_en", m_lp == 0, clk_en);
      chk("stop_mode", m_lp == 2, stop_m);
      chk("stack_regs", m_take, regs);
      chk("stack_hreg", 0, hreg);
      if (c == 1500) begin
        rst = 1; #1 rchk; mreset;
        repeat (3) @(posedge mclk);
        #1 rst = 0;
      end else begin
        r = $random(seed);
        // Each input is written once per step, so no zero-width pulse
        software_interrupt_instruction = (r[2:0] == 3'h0);
        return_from_interrupt = (r[2:0] == 3'h1);
        wt = (r[2:0] == 3'h2);
        sp = (r[2:0] == 3'h3) && (r[8:6] == 3'h0);
        ins = (r[2:0] > 3'h3);
        // Enable low about one cycle in eight
        ce = (r[5:3] != 3'h0);
        raise = (r[12:9] == 0) ? 11'(1) << (r[31:28] % 11) : '0;
        pc = r[27:12];
        if (c % 128 == 0) en = 11'($random(seed) | $random(seed));
      end
      req_s = req;
    end
    summarize;
  end
endmodule // int_arb_tb
`default_nettype wire
